// ==== design/fcd_ctrl.sv ====
// Command, mode register, refresh and low-power control of the memory device.
// Assumes clk runs well above the link clock, which is sampled as a plain pin.
// Overview of operation
// - Mode load picks regular register on bank bits 00, extended on 01.
// - After sleep rises, commands are accepted only after the wake delay.
// - DLL switch zero enables it; lock time runs after extended load.
// - Sleep low inside entry window gives self-refresh; after limit gives power-down.
// - Sleep low between window end and limit also gives self-refresh.
// - Commands sampled at link clock rise; outputs aligned to link clock edges.
// - Bank select latched with activation, bank zero bit least significant.
// - Upper address with activation, lower with address latch; bank bit 2 as A14.
// - Each operation is an activation followed next cycle by a second command.
// - Burst length field selects two or four words, others ignored.
`timescale 1ns/1ps
module fcd_ctrl #(
	parameter logic [7:0] WAKE_CYCLES = fcd_pkg::WAKE_CYCLES_DEF,
	parameter logic [7:0] ENTRY_MIN = fcd_pkg::ENTRY_MIN_DEF,
	parameter logic [7:0] ENTRY_MAX = fcd_pkg::ENTRY_MAX_DEF,
	parameter logic [7:0] VALID_LIMIT = fcd_pkg::VALID_LIMIT_DEF,
	parameter logic [7:0] DLL_LOCK = fcd_pkg::DLL_LOCK_DEF
) (
	input wire logic clk, // Block clock
	input wire logic resetn, // Asynchronous reset, active low
	input wire logic link_clk, // Memory clock pin, sampled
	input wire logic cs_n, // Chip select, active low
	input wire logic function_select, // Function select pin
	input wire logic [13:0] addr, // Address pins
	input wire logic [2:0] bank_select, // Bank pins
	input wire logic sleep_control, // Low requests sleep
	input wire logic [1:0] strobe_in, // Byte strobes in (lower, upper)
	output logic [1:0] strobe_out, // Byte strobes out
	output logic [1:0] strobe_oe_n, // Strobe drive enable, low drives
	input wire logic [15:0] dq_in, // Data pins in
	output logic [15:0] dq_out, // Data pins out
	output logic dq_oe_n, // Data drive enable, low drives
	output logic rd_req, // Read burst starts, pulse
	output logic rd_next, // One read word consumed, pulse
	input wire logic [15:0] core_rdata, // Read word from core
	output logic [2:0] acc_bank, // Bank of current access
	output logic [14:0] acc_upper, // Upper address incl. bank bit 2
	output logic [7:0] acc_lower, // Lower address
	output logic core_wvalid, // Write word valid
	input wire logic core_wready, // Core takes write word
	output logic [15:0] core_wdata, // Write word
	output logic [1:0] core_wbe, // Byte enables of write word
	output logic [7:0] reg_mode, // Regular mode register
	output logic [2:0] ext_mode, // Extended mode: dic hi, dic lo, dll switch
	output logic dll_ready, // DLL enabled and locked
	output logic in_self_refresh, // Self-refresh active
	output logic in_power_down, // Power-down active
	output logic refresh_pulse, // Auto-refresh started, pulse
	output logic cmd_refused, // Command ignored, pulse
	output logic write_overrun // Write word lost to full FIFO, sticky
);
	typedef struct packed {
		logic [2:0] lclk;
		logic [1:0] slp;
		logic [1:0] cs;
		logic [1:0] fn;
		logic [1:0][13:0] ad;
		logic [1:0][2:0] ba;
		logic [2:0][1:0] stb;
		logic [1:0][15:0] dq;
		fcd_pkg::fcd_state_e st;
		logic bl4;
		logic [7:0] mode;
		logic [2:0] ext;
		logic [7:0] cnt;
		logic [7:0] wake_len;
		logic [7:0] lock_cnt;
		logic locked;
		logic decided;
		logic pd_after;
		logic [2:0] wcnt;
		logic [1:0][2:0] lane_len;
		logic [2:0] rcnt;
		logic [15:0] dq_o;
		logic [1:0] stb_o;
		logic oe_n;
		logic rreq;
		logic rnext;
		logic [2:0] bank;
		logic [14:0] upper;
		logic [7:0] lower;
		logic selfr;
		logic pdn;
		logic refp;
		logic refused;
		logic ovr;
		logic push;
		logic [17:0] pdata;
	} fcd_ctrl_s;

	fcd_ctrl_s s_reg, s_next;
	logic [1:0] rst_q;
	logic rst_n;
	logic f_ready;
	logic f_valid;
	logic [17:0] f_data;
	logic lr, lf, cmd_on, slp_lo, wedge;
	logic [2:0] burst;

	// Write length per byte lane from its two length bits
	function automatic logic [2:0] lane_words(input logic bl4, input logic v0, input logic v1);
		if (!bl4) begin
			lane_words = v0 ? 3'h1 : 3'h2;
		end else begin
			lane_words = (v0 && v1) ? 3'h1 : ((!v0 && v1) ? 3'h2 : 3'h4);
		end
	endfunction

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_q <= 2'h0;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_n = rst_q[1];

	always_comb begin
		s_next = s_reg;
		s_next.lclk = {s_reg.lclk[1:0], link_clk};
		s_next.slp = {s_reg.slp[0], sleep_control};
		s_next.cs = {s_reg.cs[0], cs_n};
		s_next.fn = {s_reg.fn[0], function_select};
		s_next.ad = {s_reg.ad[0], addr};
		s_next.ba = {s_reg.ba[0], bank_select};
		s_next.stb = {s_reg.stb[1:0], strobe_in};
		s_next.dq = {s_reg.dq[0], dq_in};
		s_next.rreq = 1'b0;
		s_next.rnext = 1'b0;
		s_next.refp = 1'b0;
		s_next.refused = 1'b0;
		s_next.push = 1'b0;
		lr = s_reg.lclk[1] && !s_reg.lclk[2];
		lf = !s_reg.lclk[1] && s_reg.lclk[2];
		cmd_on = lr && !s_reg.cs[1];
		slp_lo = !s_reg.slp[1];
		wedge = s_reg.stb[1][0] != s_reg.stb[2][0];
		burst = s_reg.bl4 ? 3'h4 : 3'h2;
		if (!s_reg.ovr && s_reg.push && !f_ready) begin
			s_next.ovr = 1'b1;
		end
		if (lr && !s_reg.locked && s_reg.ext[0] == 1'b0) begin
			if (s_reg.lock_cnt == DLL_LOCK - 8'h01) begin
				s_next.locked = 1'b1;
			end else begin
				s_next.lock_cnt = 8'(s_reg.lock_cnt + 8'h01);
			end
		end
		unique case (s_reg.st)
			fcd_pkg::FCD_IDLE: begin
				if (lr && slp_lo) begin
					s_next.st = fcd_pkg::FCD_PDOWN;
					s_next.pdn = 1'b1;
				end else if (cmd_on) begin
					s_next.st = s_reg.fn[1] ? fcd_pkg::FCD_ACT_RD : fcd_pkg::FCD_ACT_WR;
					s_next.bank = s_reg.ba[1];
					s_next.upper = {s_reg.ba[1][2], s_reg.ad[1]};
				end
			end
			fcd_pkg::FCD_ACT_RD: begin
				if (lr && s_reg.cs[1]) begin
					if (!s_reg.locked) begin
						s_next.refused = 1'b1;
						s_next.st = fcd_pkg::FCD_IDLE;
					end else begin
						s_next.lower = s_reg.ad[1][7:0];
						s_next.rreq = 1'b1;
						s_next.cnt = 8'h00;
						s_next.st = fcd_pkg::FCD_READ;
					end
				end else if (cmd_on) begin
					if (s_reg.ba[1][1:0] == fcd_pkg::MR_SEL_REGULAR) begin
						s_next.mode = s_reg.ad[1][7:0];
						if (s_reg.ad[1][2:0] == fcd_pkg::BL_CODE_2) begin
							s_next.bl4 = 1'b0;
						end else if (s_reg.ad[1][2:0] == fcd_pkg::BL_CODE_4) begin
							s_next.bl4 = 1'b1;
						end
					end else if (s_reg.ba[1][1:0] == fcd_pkg::MR_SEL_EXTENDED) begin
						s_next.ext = {s_reg.ad[1][fcd_pkg::DIC_HI_BIT], s_reg.ad[1][fcd_pkg::DIC_LO_BIT],
							s_reg.ad[1][fcd_pkg::DS_BIT]};
						// Any extended load restarts lock; a set switch bit keeps the DLL off
						s_next.locked = 1'b0;
						s_next.lock_cnt = 8'h00;
					end
					s_next.st = fcd_pkg::FCD_IDLE;
				end
			end
			fcd_pkg::FCD_ACT_WR: begin
				if (lr && s_reg.cs[1]) begin
					s_next.lower = s_reg.ad[1][7:0];
					s_next.lane_len[0] = lane_words(s_reg.bl4, s_reg.ba[1][2], s_reg.ad[1][13]);
					s_next.lane_len[1] = lane_words(s_reg.bl4, s_reg.ad[1][12], s_reg.ad[1][11]);
					s_next.wcnt = 3'h0;
					s_next.st = fcd_pkg::FCD_WRITE;
				end else if (cmd_on) begin
					s_next.refp = 1'b1;
					s_next.cnt = 8'h00;
					s_next.decided = slp_lo;
					s_next.pd_after = 1'b0;
					s_next.selfr = slp_lo;
					s_next.st = slp_lo ? fcd_pkg::FCD_SELF : fcd_pkg::FCD_REFRESH;
				end
			end
			fcd_pkg::FCD_REFRESH: begin
				if (slp_lo && !s_reg.decided) begin
					s_next.decided = 1'b1;
					if (s_reg.cnt >= ENTRY_MIN && s_reg.cnt <= ENTRY_MAX) begin
						s_next.st = fcd_pkg::FCD_SELF;
						s_next.selfr = 1'b1;
					end else if (s_reg.cnt > ENTRY_MAX && s_reg.cnt < VALID_LIMIT) begin
						// Undefined band: self-refresh chosen, it keeps data safest
						s_next.st = fcd_pkg::FCD_SELF;
						s_next.selfr = 1'b1;
					end else begin
						s_next.pd_after = 1'b1;
					end
				end
				if (lr) begin
					s_next.cnt = 8'(s_reg.cnt + 8'h01);
					if (s_reg.cnt == fcd_pkg::REFRESH_CYCLES - 8'h01 && s_next.st == fcd_pkg::FCD_REFRESH) begin
						s_next.st = s_reg.pd_after ? fcd_pkg::FCD_PDOWN : fcd_pkg::FCD_IDLE;
						s_next.pdn = s_reg.pd_after;
					end
				end
			end
			fcd_pkg::FCD_SELF, fcd_pkg::FCD_PDOWN: begin
				if (!slp_lo) begin
					s_next.cnt = 8'h00;
					s_next.st = fcd_pkg::FCD_WAKE;
					s_next.selfr = 1'b0;
					s_next.pdn = 1'b0;
					s_next.wake_len = (s_reg.st == fcd_pkg::FCD_SELF) ? fcd_pkg::REFRESH_CYCLES
						: WAKE_CYCLES;
					if (s_reg.st == fcd_pkg::FCD_SELF) begin
						s_next.locked = 1'b0;
						s_next.lock_cnt = 8'h00;
					end
				end
			end
			fcd_pkg::FCD_WAKE: begin
				if (cmd_on) begin
					s_next.refused = 1'b1;
				end
				if (lr) begin
					s_next.cnt = 8'(s_reg.cnt + 8'h01);
					if (s_reg.cnt >= s_reg.wake_len - 8'h01) begin
						s_next.st = fcd_pkg::FCD_IDLE;
					end
				end
			end
			fcd_pkg::FCD_READ: begin
				if (s_reg.oe_n) begin
					if (lr) begin
						s_next.cnt = 8'(s_reg.cnt + 8'h01);
						if (s_reg.cnt == 8'(fcd_pkg::READ_LAT - 4'h1)) begin
							s_next.oe_n = 1'b0;
							s_next.dq_o = core_rdata;
							s_next.stb_o = 2'h3;
							s_next.rnext = 1'b1;
							s_next.rcnt = 3'h1;
						end
					end
				end else if (lr || lf) begin
					if (s_reg.rcnt == burst) begin
						s_next.oe_n = 1'b1;
						s_next.stb_o = 2'h0;
						s_next.st = fcd_pkg::FCD_IDLE;
					end else begin
						s_next.dq_o = core_rdata;
						s_next.stb_o = ~s_reg.stb_o;
						s_next.rnext = 1'b1;
						s_next.rcnt = 3'(s_reg.rcnt + 3'h1);
					end
				end
			end
			fcd_pkg::FCD_WRITE: begin
				if (wedge) begin
					// Every edge of strobe 0 counts, masked words are simply not enabled
					s_next.push = 1'b1;
					s_next.pdata = {s_reg.wcnt < s_reg.lane_len[1], s_reg.wcnt < s_reg.lane_len[0],
						s_reg.dq[1]};
					s_next.wcnt = 3'(s_reg.wcnt + 3'h1);
					if (3'(s_reg.wcnt + 3'h1) == burst) begin
						s_next.st = fcd_pkg::FCD_IDLE;
					end
				end
			end
			default: begin
				s_next.st = fcd_pkg::FCD_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
			s_reg.st <= fcd_pkg::FCD_IDLE;
			s_reg.slp <= 2'h3; // Idle level, so no false sleep request follows reset
			s_reg.cs <= 2'h3; // Idle level, so no false command follows reset
			s_reg.oe_n <= 1'b1;
			s_reg.mode <= fcd_pkg::REG_MODE_RESET;
			s_reg.bl4 <= 1'b1;
			s_reg.ext <= 3'h1;
		end else begin
			s_reg <= s_next;
		end
	end

	// Pin-side writes cannot be stalled; a full FIFO drops the word and flags it
	fcd_fifo #(
		.WIDTH(fcd_pkg::WFIFO_WIDTH),
		.DEPTH(fcd_pkg::WFIFO_DEPTH)
	) u_wfifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(s_reg.push),
		.in_ready(f_ready),
		.in_data(s_reg.pdata),
		.out_valid(f_valid),
		.out_ready(core_wready),
		.out_data(f_data)
	);

	assign core_wvalid = f_valid;
	assign core_wdata = f_data[15:0];
	assign core_wbe = f_data[17:16];
	assign strobe_out = s_reg.stb_o;
	assign strobe_oe_n = {s_reg.oe_n, s_reg.oe_n};
	assign dq_out = s_reg.dq_o;
	assign dq_oe_n = s_reg.oe_n;
	assign rd_req = s_reg.rreq;
	assign rd_next = s_reg.rnext;
	assign acc_bank = s_reg.bank;
	assign acc_upper = s_reg.upper;
	assign acc_lower = s_reg.lower;
	assign reg_mode = s_reg.mode;
	assign ext_mode = s_reg.ext;
	assign dll_ready = s_reg.locked;
	assign in_self_refresh = s_reg.selfr;
	assign in_power_down = s_reg.pdn;
	assign refresh_pulse = s_reg.refp;
	assign cmd_refused = s_reg.refused;
	assign write_overrun = s_reg.ovr;
endmodule // fcd_ctrl

// ==== design/fcd_pkg.sv ====
// Shared constants for the fast cycle DRAM command and power control block.
// Assumes link-side counts are in link clock cycles, found by edge sampling.
package fcd_pkg;
	// Second-command bank codes that pick a mode register
	localparam logic [1:0] MR_SEL_REGULAR = 2'h0;
	localparam logic [1:0] MR_SEL_EXTENDED = 2'h1;
	// Regular mode register fields
	localparam int BL_LSB = 0;
	localparam int BT_BIT = 3;
	localparam int CL_LSB = 4;
	localparam int TE_BIT = 7;
	localparam logic [2:0] BL_CODE_2 = 3'h1;
	localparam logic [2:0] BL_CODE_4 = 3'h2;
	localparam logic [2:0] CL_CODE_4 = 3'h4;
	localparam logic [7:0] REG_MODE_RESET = 8'h42;
	// Extended mode register fields
	localparam int DS_BIT = 0;
	localparam int DIC_LO_BIT = 1;
	localparam int DIC_HI_BIT = 6;
	// Latencies in link cycles
	localparam logic [3:0] READ_LAT = 4'h4;
	localparam logic [3:0] WRITE_LAT = 4'h3;
	// Link cycle counts
	localparam logic [7:0] REFRESH_CYCLES = 8'h12;
	localparam logic [7:0] WAKE_CYCLES_DEF = 8'h02;
	localparam logic [7:0] ENTRY_MIN_DEF = 8'h00;
	localparam logic [7:0] ENTRY_MAX_DEF = 8'h01;
	localparam logic [7:0] VALID_LIMIT_DEF = 8'h03;
	localparam logic [7:0] DLL_LOCK_DEF = 8'hC8;
	// Write FIFO
	localparam int WFIFO_DEPTH = 4;
	localparam int WFIFO_WIDTH = 18;

	typedef enum logic [3:0] {
		FCD_IDLE, FCD_ACT_RD, FCD_ACT_WR, FCD_READ, FCD_WRITE,
		FCD_REFRESH, FCD_SELF, FCD_PDOWN, FCD_WAKE
	} fcd_state_e;
endpackage

// ==== design/fcd_fifo.sv ====
// Small FIFO with a registered output stage.
// Assumes both sides on one clock; the read side may stall to apply back-pressure.
`timescale 1ns/1ps
module fcd_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 4
) (
	input wire logic clk, // Clock
	input wire logic rst_n, // Synchronised reset, active low
	input wire logic in_valid, // Write word offered
	output logic in_ready, // Room for a word
	input wire logic [WIDTH-1:0] in_data, // Word in
	output logic out_valid, // Output word valid
	input wire logic out_ready, // Consumer takes word
	output logic [WIDTH-1:0] out_data // Word out, registered
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [PW:0] cnt;
		logic ov;
		logic [WIDTH-1:0] od;
	} fcd_fifo_s;

	fcd_fifo_s s_reg, s_next;
	logic push, pop;

	assign in_ready = (s_reg.cnt < (PW+1)'(DEPTH));
	assign out_valid = s_reg.ov;
	assign out_data = s_reg.od;

	always_comb begin
		s_next = s_reg;
		push = in_valid && in_ready;
		pop = (!s_reg.ov || out_ready) && (s_reg.cnt != '0);
		if (push) begin
			s_next.mem[s_reg.wp] = in_data;
			s_next.wp = PW'(s_reg.wp + 1'b1);
		end
		if (pop) begin
			s_next.od = s_reg.mem[s_reg.rp];
			s_next.rp = PW'(s_reg.rp + 1'b1);
			s_next.ov = 1'b1;
		end else if (out_ready) begin
			s_next.ov = 1'b0;
		end
		s_next.cnt = (PW+1)'(s_reg.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop});
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule // fcd_fifo

// ==== test/fcd_ctrl_checker.sv ====
// Checker: port-level timing relations of the command and power control block.
// Assumes one clock domain with resetn as its reset; bound to the top module below.
`timescale 1ns/1ps
module fcd_ctrl_checker (
	input wire logic clk, // Block clock
	input wire logic resetn, // Reset, active low
	input wire logic rd_req, // Read start pulse
	input wire logic rd_next, // Read word pulse
	input wire logic dq_oe_n, // Data drive enable
	input wire logic [1:0] strobe_oe_n, // Strobe drive enable
	input wire logic [2:0] ext_mode, // Extended mode
	input wire logic dll_ready, // DLL ready
	input wire logic in_self_refresh, // Self-refresh level
	input wire logic in_power_down, // Power-down level
	input wire logic refresh_pulse, // Refresh pulse
	input wire logic cmd_refused, // Refusal pulse
	input wire logic write_overrun, // Sticky overrun
	input wire logic core_wvalid, // Write word valid
	input wire logic core_wready, // Core takes word
	input wire logic [15:0] core_wdata, // Write word
	input wire logic [1:0] core_wbe // Byte enables
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_refused_pulse; cmd_refused |=> !cmd_refused; endproperty
	a_refused_pulse: assert property (p_refused_pulse) else $error("long refusal pulse");
	property p_rd_req_pulse; rd_req |=> !rd_req; endproperty
	a_rd_req_pulse: assert property (p_rd_req_pulse) else $error("long read start");
	property p_ref_pulse; refresh_pulse |=> !refresh_pulse; endproperty
	a_ref_pulse: assert property (p_ref_pulse) else $error("long refresh pulse");
	property p_modes_excl; !(in_self_refresh && in_power_down); endproperty
	a_modes_excl: assert property (p_modes_excl) else $error("both sleep modes");
	property p_quiet;
		(in_self_refresh || in_power_down) |-> dq_oe_n && strobe_oe_n == 2'h3;
	endproperty
	a_quiet: assert property (p_quiet) else $error("pins driven asleep");
	property p_dll_enable; dll_ready |-> !ext_mode[0]; endproperty
	a_dll_enable: assert property (p_dll_enable) else $error("ready with DLL off");
	property p_rd_latency; rd_req |-> ##[30:70] rd_next; endproperty
	a_rd_latency: assert property (p_rd_latency) else $error("read data late");
	property p_rd_drive; rd_next |=> !dq_oe_n && strobe_oe_n == 2'h0; endproperty
	a_rd_drive: assert property (p_rd_drive) else $error("read word not driven");
	property p_whold;
		core_wvalid && !core_wready |=> core_wvalid && $stable({core_wbe, core_wdata});
	endproperty
	a_whold: assert property (p_whold) else $error("write word dropped");
	property p_overrun; write_overrun |=> write_overrun; endproperty
	a_overrun: assert property (p_overrun) else $error("overrun cleared");
endmodule // fcd_ctrl_checker

bind fcd_ctrl fcd_ctrl_checker fcd_ctrl_checker_inst (.clk, .resetn, .rd_req, .rd_next, .dq_oe_n,
	.strobe_oe_n, .ext_mode, .dll_ready, .in_self_refresh, .in_power_down, .refresh_pulse,
	.cmd_refused, .write_overrun, .core_wvalid, .core_wready, .core_wdata, .core_wbe);

// ==== test/fcd_host.sv ====
// Memory controller model: free-running link clock, command pairs, write bursts, sleep pin.
// Assumes the bench calls one task at a time and resolves the shared data and strobe pins.
`timescale 1ns/1ps
module fcd_host (
	output logic link_clk = 1'h0, // Memory clock
	output logic cs_n = 1'h1, // Chip select, active low
	output logic function_select = 1'h0, // Function select
	output logic [13:0] addr = 14'h0, // Address pins
	output logic [2:0] bank_select = 3'h0, // Bank pins
	output logic sleep_control = 1'h1, // Low requests sleep
	output logic [1:0] strobe_in = 2'h0, // Write strobes
	output logic [15:0] dq_in = 16'h0 // Write data
);
	// Runs free so power-down sees a steady clock
	initial begin
		#7;
		forever #24 link_clk = ~link_clk;
	end
	task automatic pair(input logic fn, input logic [2:0] ba, input logic [13:0] a,
		input logic cs2, input logic [2:0] ba2, input logic [13:0] a2);
		@(negedge link_clk);
		cs_n <= 1'h0;
		function_select <= fn;
		bank_select <= ba;
		addr <= a;
		@(negedge link_clk);
		cs_n <= cs2;
		bank_select <= ba2;
		addr <= a2;
		// Don't-care pins are not held at their last value
		@(negedge link_clk);
		cs_n <= 1'h1;
		function_select <= ~fn;
		bank_select <= ~ba2;
		addr <= ~a2;
	endtask
	task automatic burst(input int n, input logic [63:0] ws);
		repeat (2) @(negedge link_clk);
		for (int k = 0; k < n; k++) begin
			@(link_clk);
			dq_in <= ws[16*k +: 16];
			#12 strobe_in <= ~strobe_in;
		end
		@(link_clk);
		dq_in <= ~dq_in;
	endtask
	task automatic set_sleep(input logic v);
		@(negedge link_clk);
		sleep_control <= v;
	endtask
	task automatic ref_sleep(input int d);
		fork
			pair(1'h0, 3'h0, 14'h0, 1'h0, 3'h0, 14'h0);
			begin
				repeat (d + 2) @(negedge link_clk);
				sleep_control <= 1'h0;
			end
		join
	endtask
endmodule // fcd_host

// ==== test/fcd_ctrl_tb.sv ====
// Testbench: reads, mode loads, writes through the FIFO, refresh and sleep entry and exit.
// Assumes the checker is bound in and fcd_host drives the memory-side pins.
`timescale 1ns/1ps
module fcd_ctrl_tb;
	logic clk = 1'h0;
	logic resetn = 1'h0;
	logic link_clk, cs_n, function_select, sleep_control, core_wready;
	logic [13:0] addr;
	logic [2:0] bank_select, acc_bank, ext_mode, exp_bank;
	logic [1:0] strobe_in, strobe_out, strobe_oe_n, core_wbe, host_strobe, rdy_mode = 2'h2;
	logic [15:0] dq_in, dq_out, host_dq, core_wdata, core_rdata = 16'h0, exp_rd = 16'h0;
	logic [14:0] acc_upper, exp_up;
	logic [7:0] acc_lower, reg_mode, exp_lo;
	logic dq_oe_n, rd_req, rd_next, core_wvalid, dll_ready, in_self_refresh, in_power_down;
	logic refresh_pulse, cmd_refused, write_overrun;
	logic [1:0] exp_stb = 2'h0;
	int n_errors = 0, cmp_count = 0, seed = 32'h6b35, rd_words = 0, refused = 0, refreshes = 0;
	logic [17:0] wq[$];
	// Shared pins resolve to whichever side drives them
	assign dq_in = dq_oe_n ? host_dq : dq_out;
	assign strobe_in = (strobe_oe_n & host_strobe) | (~strobe_oe_n & strobe_out);
	fcd_ctrl #(.DLL_LOCK(8'h04)) fcd_ctrl_inst (.clk, .resetn, .link_clk, .cs_n, .function_select,
		.addr, .bank_select, .sleep_control, .strobe_in, .strobe_out, .strobe_oe_n, .dq_in,
		.dq_out, .dq_oe_n, .rd_req, .rd_next, .core_rdata, .acc_bank, .acc_upper, .acc_lower,
		.core_wvalid, .core_wready, .core_wdata, .core_wbe, .reg_mode, .ext_mode, .dll_ready,
		.in_self_refresh, .in_power_down, .refresh_pulse, .cmd_refused, .write_overrun);
	fcd_host fcd_host_inst (.link_clk, .cs_n, .function_select, .addr, .bank_select,
		.sleep_control, .strobe_in(host_strobe), .dq_in(host_dq));
	initial begin
		forever #2 clk = ~clk;
	end
	task automatic stop_test();
		if (n_errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	always @(posedge clk) begin
		core_wready <= rdy_mode[1] | (rdy_mode[0] & 1'($random(seed)));
		if (rd_next === 1'h1) begin
			exp_rd = 16'($random(seed));
			core_rdata <= exp_rd;
		end
	end
	// Settled values are looked at mid-cycle
	always @(negedge clk) begin
		if (rd_next === 1'h1) begin
			// First word of a burst raises both strobes, each later word flips them
			exp_stb = (rd_words == 0) ? 2'h3 : ~exp_stb;
			rd_words++;
			chk(dq_out, exp_rd);
			chk(strobe_out, exp_stb);
		end
		if (rd_req === 1'h1)
			chk({acc_bank, acc_upper, acc_lower}, {exp_bank, exp_up, exp_lo});
		if (cmd_refused === 1'h1)
			refused++;
		if (refresh_pulse === 1'h1)
			refreshes++;
		if (core_wvalid === 1'h1 && core_wready === 1'h1) begin
			if (wq.size() == 0)
				chk(32'h1, 32'h0);
			else
				chk({core_wbe, core_wdata}, wq.pop_front());
		end
	end
	task automatic wait_link(input int n);
		repeat (n) @(posedge link_clk);
	endtask
	task automatic do_read(input logic [2:0] ba, input logic [13:0] ua, input logic [7:0] lo,
		input int words);
		exp_bank = ba;
		exp_up = {ba[2], ua};
		exp_lo = lo;
		rd_words = 0;
		fcd_host_inst.pair(1'h1, ba, ua, 1'h1, ~ba, {~ua[13:8], lo});
		wait_link(10);
		chk(rd_words, words);
	endtask
	// Opcodes keep the test bit low, also where a reserved code is tried on purpose
	task automatic do_mrs(input logic [1:0] sel, input logic [13:0] op);
		fcd_host_inst.pair(1'h1, 3'h0, 14'($random(seed)), 1'h0, {1'h0, sel}, op);
		wait_link(4);
	endtask
	function automatic int vw_len(input int bl, input logic v0, input logic v1);
		if (bl == 2)
			return v0 ? 1 : 2;
		return (v0 && v1) ? 1 : (!v0 && v1) ? 2 : 4;
	endfunction
	// vw holds lane 0 length bits then lane 1 length bits
	task automatic do_write(input logic [3:0] vw, input int bl);
		logic [63:0] ws;
		int l0, l1;
		ws = {$random(seed), $random(seed)};
		l0 = vw_len(bl, vw[3], vw[2]);
		l1 = vw_len(bl, vw[1], vw[0]);
		for (int k = 0; k < bl; k++)
			wq.push_back({k < l1, k < l0, ws[16*k +: 16]});
		fcd_host_inst.pair(1'h0, 3'($random(seed)), 14'($random(seed)), 1'h1, {vw[3], 2'h0},
			{vw[2:0], 11'($random(seed))});
		fcd_host_inst.burst(bl, ws);
		wait_link(6);
	endtask
	initial begin
		#100000;
		n_errors++;
		stop_test();
	end
	initial begin
		repeat (12) @(posedge clk);
		resetn <= 1'h1;
		repeat (8) @(posedge clk);
		rdy_mode <= 2'h1;
		do_read(3'h1, 14'h0123, 8'h45, 0);
		chk(refused, 1);
		do_mrs(2'h1, 14'h0040);
		chk({reg_mode, ext_mode}, {8'h42, 3'h4});
		wait_link(8);
		chk(dll_ready, 1);
		for (int b = 0; b < 8; b++)
			do_read(3'(b), 14'($random(seed)), 8'($random(seed)), 4);
		do_mrs(2'h0, 14'h0041);
		chk(reg_mode, 8'h41);
		do_read(3'h5, 14'h2F0E, 8'h81, 2);
		do_mrs(2'h2, 14'h0000);
		chk({reg_mode, ext_mode}, {8'h41, 3'h4});
		do_mrs(2'h0, 14'h0043);
		do_read(3'h6, 14'h1ABC, 8'h7E, 2);
		do_write(4'h2, 2);
		do_mrs(2'h0, 14'h0042);
		do_write(4'hD, 4);
		do_write(4'hA, 4);
		chk(wq.size(), 0);
		// Sleep falling 0 to 3 link rises after the refresh gives self-refresh; 4 is past the limit
		for (int d = 0; d < 5; d++) begin
			refreshes = 0;
			refused = 0;
			fcd_host_inst.ref_sleep(d);
			wait_link(24);
			chk({in_self_refresh, in_power_down}, d < 4 ? 2'h2 : 2'h1);
			chk(refreshes, 1);
			fcd_host_inst.set_sleep(1'h1);
			fcd_host_inst.pair(1'h0, 3'h0, 14'h0, 1'h1, 3'h0, 14'h0);
			wait_link(20);
			chk(refused, 1);
			chk({in_self_refresh, in_power_down, dll_ready}, 3'h1);
		end
		// Sleep from idle gives plain power-down; a read is taken once the wake delay has run
		refused = 0;
		fcd_host_inst.set_sleep(1'h0);
		wait_link(3);
		chk({in_self_refresh, in_power_down}, 2'h1);
		fcd_host_inst.set_sleep(1'h1);
		wait_link(2);
		do_read(3'h3, 14'h0A5C, 8'h3C, 4);
		chk(refused, 0);
		rdy_mode <= 2'h0;
		do_write(4'hA, 4);
		do_write(4'hA, 4);
		chk({write_overrun, core_wvalid}, 2'h3);
		rdy_mode <= 2'h2;
		wait_link(4);
		chk({wq.size() <= 4, core_wvalid}, 2'h2);
		wq.delete();
		@(posedge clk);
		resetn <= 1'h0;
		repeat (3) @(posedge clk);
		resetn <= 1'h1;
		repeat (4) @(posedge clk);
		chk({write_overrun, reg_mode, ext_mode, dll_ready}, {1'h0, 8'h42, 3'h1, 1'h0});
		stop_test();
	end
endmodule // fcd_ctrl_tb
